// [src/fifo_bm_device.sv]
/*
 * FIFO device end: 256 x 36 store, port B bus matching, flags, mailboxes.
 * Assumes ports A and B both run on mclk; the controller obeys the flags.
 */
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fifo_bm_device (
    fifo_bm_if.device bus
);
    typedef struct packed {
        logic [8:0]  wp;
        logic [8:0]  wpD1;
        logic [8:0]  wpD2;
        logic [8:0]  rp;
        logic [8:0]  rpFree;
        logic [8:0]  rpFreeD1;
        logic [1:0]  portion;
        logic        holdValid;
        logic [35:0] holdWord;
        logic [35:0] bOut;
        logic [35:0] aOut;
        logic [35:0] mail1;
        logic [35:0] mail2;
        logic        mail1Full;
        logic        mail2Full;
        logic        emptyF;
        logic        fullF;
        logic        aeF;
        logic        afF;
        logic        bigEnd;
        logic        fall_through_mode;
        logic        mrPrev;
    } devState_s;

    devState_s             s_r;
    devState_s             s_nxt;
    logic [35:0]           mem [fifo_bm_pkg::DEPTH];
    fifo_bm_pkg::busSize_e busSize;
    logic [1:0]            lastIdx;
    logic [35:0]           mask;
    logic [35:0]           headWord;
    logic [35:0]           laneWord;
    logic [1:0]            lanePortion;
    logic [35:0]           laneOut;
    logic                  aWr;
    logic                  aRd;
    logic                  bWr;
    logic                  bRd;
    logic                  fifoWr;
    logic                  fifoRd;
    logic                  avail;
    logic [8:0]            visWp;

    assign busSize  = fifo_bm_pkg::decodeSize(bus.busMatchSelect, bus.sizeSelect);
    assign lastIdx  = fifo_bm_pkg::lastPortion(busSize);
    assign mask     = fifo_bm_pkg::laneMask(busSize);
    assign headWord = mem[s_r.rp[7:0]];
    assign aWr      = !bus.portAChipSelectN && bus.portAWriteRead && bus.portAEnable;
    assign aRd      = !bus.portAChipSelectN && !bus.portAWriteRead && bus.portAEnable;
    assign bWr      = !bus.portBChipSelectN && !bus.portBWriteRead && bus.portBEnable;
    assign bRd      = !bus.portBChipSelectN && bus.portBWriteRead && bus.portBEnable;
    assign fifoWr   = aWr && !bus.portAMailSelect && s_r.fullF;
    assign fifoRd   = bRd && !bus.portBMailSelect && s_r.emptyF;
    // fall-through sees writes one clock later so the word lands on the fourth edge
    assign visWp    = s_r.fall_through_mode ? s_r.wpD2 : s_r.wpD1;                    // [R7] [R8]
    assign avail    = visWp != s_r.rp;

    // which word and portion the output register takes this edge
    always_comb begin
        laneWord    = headWord;
        lanePortion = 2'h0;
        if (!s_r.fall_through_mode) begin
            laneWord    = (s_r.portion == 2'h0) ? headWord : s_r.holdWord; // [R20]
            lanePortion = s_r.portion;
        end else if (fifoRd && s_r.portion != lastIdx) begin
            laneWord    = s_r.holdWord;                                  // [R20]
            lanePortion = s_r.portion + 2'h1;
        end
    end

    portion_select u_portion (
        .longWord  (laneWord),
        .busSize   (busSize),
        .bigEndian (s_r.bigEnd),
        .portion   (lanePortion),
        .laneOut   (laneOut)
    );

    always_comb begin
        s_nxt        = s_r;
        s_nxt.mrPrev = bus.masterResetN;
        s_nxt.wpD1   = s_r.wp;
        s_nxt.wpD2   = s_r.wpD1;
        s_nxt.rpFreeD1 = s_r.rpFree;

        if (fifoWr) begin
            s_nxt.wp = s_r.wp + 9'h001;
        end

        if (fifoRd) begin
            if (!s_r.fall_through_mode || s_r.portion != lastIdx) begin
                s_nxt.bOut = laneOut;
            end
            if (!s_r.fall_through_mode && s_r.portion == 2'h0) begin
                s_nxt.holdWord = headWord;                               // [R20]
                s_nxt.rp       = s_r.rp + 9'h001;
            end
            if (s_r.portion == lastIdx) begin
                s_nxt.portion   = 2'h0;                                  // [R22]
                s_nxt.rpFree    = s_r.rpFree + 9'h001;                   // [R11]
                s_nxt.holdValid = 1'b0;
            end else begin
                s_nxt.portion = s_r.portion + 2'h1;                      // [R22]
            end
        end
        if (s_r.fall_through_mode && !s_nxt.holdValid && avail) begin
            s_nxt.holdWord  = headWord;                                  // [R7]
            s_nxt.rp        = s_r.rp + 9'h001;
            s_nxt.holdValid = 1'b1;
            s_nxt.portion   = 2'h0;
            s_nxt.bOut      = laneOut;
        end

        // mailbox A to B: lanes limited by the port B size
        if (aWr && bus.portAMailSelect && !s_r.mail1Full) begin
            s_nxt.mail1     = bus.aDataIn & mask;                        // [R14]
            s_nxt.mail1Full = 1'b1;
        end
        if (bRd && bus.portBMailSelect) begin
            s_nxt.bOut      = s_r.mail1 & mask;                          // [R14]
            s_nxt.mail1Full = 1'b0;
        end
        // mailbox B to A
        if (bWr && bus.portBMailSelect && !s_r.mail2Full) begin
            s_nxt.mail2     = bus.bDataIn & mask;                        // [R15]
            s_nxt.mail2Full = 1'b1;
        end
        if (aRd && bus.portAMailSelect) begin
            s_nxt.aOut      = s_r.mail2 & mask;                          // [R15]
            s_nxt.mail2Full = 1'b0;
        end

        // flags; write side sees freed space one clock late, read side sees fill late
        if (s_r.fall_through_mode) begin
            s_nxt.emptyF = s_nxt.holdValid;                              // [R9]
        end else begin
            s_nxt.emptyF = (s_r.wpD1 != s_nxt.rp) || (s_nxt.portion != 2'h0); // [R8] [R9]
        end
        s_nxt.fullF = (s_nxt.wp - s_r.rpFreeD1) != fifo_bm_pkg::DEPTH_CNT;    // [R10]
        s_nxt.aeF   = (s_r.wpD1 - s_nxt.rpFree) > fifo_bm_pkg::AE_OFFSET;    // [R12]
        s_nxt.afF   = (s_nxt.wp - s_r.rpFreeD1)
                      < (fifo_bm_pkg::DEPTH_CNT - fifo_bm_pkg::AF_OFFSET);   // [R13]

        // endian and timing mode caught on the release edge of master reset
        if (bus.masterResetN && !s_r.mrPrev) begin
            s_nxt.bigEnd = bus.endianSelect;                             // [R21]
            s_nxt.fall_through_mode   = bus.fallThroughMode;
        end

        // master reset clears data and flags but keeps the captured modes
        if (!bus.masterResetN) begin
            s_nxt        = '0;
            s_nxt.bigEnd = s_r.bigEnd;
            s_nxt.fall_through_mode   = s_r.fall_through_mode;
        end
    end

    // storage has no reset; pointers guard every read
    always_ff @(posedge bus.mclk) begin
        if (fifoWr && bus.masterResetN) begin
            mem[s_r.wp[7:0]] <= bus.aDataIn;
        end
    end

    always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
        if (!bus.arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.aDataOut         = s_r.aOut;
    assign bus.bDataOut         = s_r.bOut;
    assign bus.emptyFlagN       = s_r.emptyF;
    assign bus.fullFlagN        = s_r.fullF;
    assign bus.almostEmptyFlagN = s_r.aeF;
    assign bus.almostFullFlagN  = s_r.afF;
    assign bus.mailToBFlagN     = !s_r.mail1Full;
    assign bus.mailToAFlagN     = !s_r.mail2Full;
endmodule // fifo_bm_device
`default_nettype wire

// [src/fifo_bm_host.sv]
/*
 * Controller end: turns user requests into port A and B cycles.
 * Assumes the device end on the same interface and clock.
 */
`timescale 1ns/10ps
`default_nettype none
module fifo_bm_host (
    fifo_bm_if.host     bus,
    input  wire logic        chainMode,
    input  wire logic        cfgBusMatch,
    input  wire logic        cfgSize,
    input  wire logic        cfgBigEndian,
    input  wire logic        cfgFallThrough,
    input  wire logic        userResetN,
    input  wire logic        userWrite,
    input  wire logic        userWriteMail,
    input  wire logic [35:0] userWriteData,
    input  wire logic        userRead,
    input  wire logic        userReadMail,
    input  wire logic        userMailWrite,
    input  wire logic [35:0] userMailData,
    input  wire logic        userMailRead,
    output logic             writeDone,
    output logic             refused,
    output logic [35:0]      readData,
    output logic             readValid,
    output logic [35:0]      mailData,
    output logic             mailValid
);
    typedef struct packed {
        logic [35:0] aData;
        logic [35:0] bData;
        logic        aCsN;
        logic        aWr;
        logic        aEn;
        logic        aMail;
        logic        bCsN;
        logic        bRdSel;
        logic        bEn;
        logic        bMail;
        logic        bm;
        logic        size;
        logic        endian;
        logic        fall_through_mode;
        logic        mrN;
        logic        capLate;
        logic        capMail;
        logic        done;
        logic        refused;
        logic [35:0] rdData;
        logic        rdValid;
        logic [35:0] mbData;
        logic        mbValid;
    } hostState_s;

    hostState_s h_r;
    hostState_s h_nxt;
    logic       mailOk;
    logic       aBusy;
    logic       bBusy;

    assign mailOk = !chainMode;                                          // [R16]
    assign aBusy  = h_r.aEn;
    assign bBusy  = h_r.bEn;

    always_comb begin
        h_nxt         = h_r;
        h_nxt.aCsN    = 1'b1;
        h_nxt.aEn     = 1'b0;
        h_nxt.aMail   = 1'b0;
        h_nxt.bCsN    = 1'b1;
        h_nxt.bEn     = 1'b0;
        h_nxt.bMail   = 1'b0;
        h_nxt.done    = 1'b0;
        h_nxt.refused = 1'b0;
        h_nxt.rdValid = 1'b0;
        h_nxt.mbValid = 1'b0;
        // read data land one clock after the strobe edge, so capture a cycle later
        h_nxt.capLate = h_r.bEn && h_r.bRdSel && (h_r.bMail || !h_r.fall_through_mode);
        h_nxt.capMail = h_r.aEn && !h_r.aWr && h_r.aMail;
        // selects track user config; user must keep them static
        h_nxt.bm      = cfgBusMatch;                                     // [R2]
        h_nxt.size    = cfgSize;
        h_nxt.endian  = cfgBigEndian;
        h_nxt.fall_through_mode    = cfgFallThrough;
        h_nxt.mrN     = userResetN;

        // port A: one request at a time, flags re-read after each cycle
        if (userWrite) begin
            if (!aBusy && (userWriteMail ? (mailOk && bus.mailToBFlagN) : bus.fullFlagN)) begin
                h_nxt.aCsN  = 1'b0;
                h_nxt.aWr   = 1'b1;
                h_nxt.aEn   = 1'b1;
                h_nxt.aMail = userWriteMail;
                h_nxt.aData = userWriteData;
                h_nxt.done  = 1'b1;
            end else begin
                h_nxt.refused = 1'b1;
            end
        end else if (userMailRead) begin
            if (!aBusy && mailOk && !bus.mailToAFlagN) begin
                h_nxt.aCsN    = 1'b0;
                h_nxt.aWr     = 1'b0;
                h_nxt.aEn     = 1'b1;
                h_nxt.aMail   = 1'b1;
            end else begin
                h_nxt.refused = 1'b1;
            end
        end

        // port B
        if (userRead) begin
            if (!bBusy && (userReadMail ? (mailOk && !bus.mailToBFlagN) : bus.emptyFlagN)) begin
                h_nxt.bCsN    = 1'b0;
                h_nxt.bRdSel  = 1'b1;
                h_nxt.bEn     = 1'b1;
                h_nxt.bMail   = userReadMail;
            end else begin
                h_nxt.refused = 1'b1;
            end
        end else if (userMailWrite) begin
            if (!bBusy && mailOk && bus.mailToAFlagN) begin
                h_nxt.bCsN   = 1'b0;
                h_nxt.bRdSel = 1'b0;
                h_nxt.bEn    = 1'b1;
                h_nxt.bMail  = 1'b1;
                h_nxt.bData  = userMailData;
                h_nxt.done   = 1'b1;
            end else begin
                h_nxt.refused = 1'b1;
            end
        end

        // fall-through data stand before the read; others follow it
        if (h_r.capLate || (h_r.bEn && h_r.bRdSel && !h_r.bMail && h_r.fall_through_mode)) begin
            h_nxt.rdData  = bus.bDataOut;
            h_nxt.rdValid = 1'b1;
        end
        if (h_r.capMail) begin
            h_nxt.mbData  = bus.aDataOut;
            h_nxt.mbValid = 1'b1;
        end
    end

    always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
        if (!bus.arst_n) begin
            h_r      <= '0;
            h_r.aCsN <= 1'b1;
            h_r.bCsN <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign bus.aDataIn          = h_r.aData;
    assign bus.bDataIn          = h_r.bData;
    assign bus.portAChipSelectN = h_r.aCsN;
    assign bus.portAWriteRead   = h_r.aWr;
    assign bus.portAEnable      = h_r.aEn;
    assign bus.portAMailSelect  = h_r.aMail;
    assign bus.portBChipSelectN = h_r.bCsN;
    assign bus.portBWriteRead   = h_r.bRdSel;
    assign bus.portBEnable      = h_r.bEn;
    assign bus.portBMailSelect  = h_r.bMail;
    assign bus.busMatchSelect   = h_r.bm;
    assign bus.sizeSelect       = h_r.size;
    assign bus.endianSelect     = h_r.endian;
    assign bus.fallThroughMode  = h_r.fall_through_mode;
    assign bus.masterResetN     = h_r.mrN;
    assign writeDone            = h_r.done;
    assign refused              = h_r.refused;
    assign readData             = h_r.rdData;
    assign readValid            = h_r.rdValid;
    assign mailData             = h_r.mbData;
    assign mailValid            = h_r.mbValid;
endmodule // fifo_bm_host
`default_nettype wire

// [src/fifo_bm_if.sv]
/*
 * Pins between the FIFO device and the controlling party.
 * Assumes both ends share mclk; data buses are split per direction.
 */
`timescale 1ns/10ps
`default_nettype none
interface fifo_bm_if (
    input  wire logic mclk,
    input  wire logic arst_n
);
    logic [35:0] aDataIn;
    logic [35:0] aDataOut;
    logic [35:0] bDataIn;
    logic [35:0] bDataOut;
    logic        portAChipSelectN;
    logic        portAWriteRead;
    logic        portAEnable;
    logic        portAMailSelect;
    logic        portBChipSelectN;
    logic        portBWriteRead;
    logic        portBEnable;
    logic        portBMailSelect;
    logic        busMatchSelect;
    logic        sizeSelect;
    logic        endianSelect;
    logic        fallThroughMode;
    logic        masterResetN;
    logic        emptyFlagN;
    logic        fullFlagN;
    logic        almostEmptyFlagN;
    logic        almostFullFlagN;
    logic        mailToBFlagN;
    logic        mailToAFlagN;

    modport device (
        input  mclk, arst_n, aDataIn, bDataIn, portAChipSelectN, portAWriteRead,
               portAEnable, portAMailSelect, portBChipSelectN, portBWriteRead,
               portBEnable, portBMailSelect, busMatchSelect, sizeSelect,
               endianSelect, fallThroughMode, masterResetN,
        output aDataOut, bDataOut, emptyFlagN, fullFlagN, almostEmptyFlagN,
               almostFullFlagN, mailToBFlagN, mailToAFlagN
    );
    modport host (
        input  mclk, arst_n, aDataOut, bDataOut, emptyFlagN, fullFlagN,
               almostEmptyFlagN, almostFullFlagN, mailToBFlagN, mailToAFlagN,
        output aDataIn, bDataIn, portAChipSelectN, portAWriteRead,
               portAEnable, portAMailSelect, portBChipSelectN, portBWriteRead,
               portBEnable, portBMailSelect, busMatchSelect, sizeSelect,
               endianSelect, fallThroughMode, masterResetN
    );
endinterface
`default_nettype wire

// [src/fifo_bm_pkg.sv]
/*
 * Constants, types and helpers used by the bus-matching FIFO device end and the bench.
 * Assumes one clock (mclk) for both ports and a single-clock testbench.
 */
//Contract
//R1: long word mode passes 36 bits unchanged
//R2: selects static; endian captured only at reset
//R3: word mode two reads, endian picks half
//R4: byte mode four reads, endian picks order
//R5: word reads leave upper lines undefined
//R6: byte reads leave upper lanes undefined
//R7: fall-through fills output within three clocks
//R8: standard empty flag rises after write
//R9: empty drops only on final portion read
//R10: full flag rises after freeing read
//R11: space freed at final portion read
//R12: almost-empty rises after filling write
//R13: almost-full rises after draining read
//R14: A-to-B mailbox width follows bus size
//R15: B-to-A mailbox width follows bus size
//R16: chained devices tie mailbox selects low
//R17: chain transfer clock is faster port clock
//R18: chain fill latency (N-1)*4 plus 3
//R19: chain space latency (N-1)*3 plus 2
//R20: first portion out, remainder held aside
//R21: endian sampled at master reset release
//R22: portion counter steps and wraps per word
package fifo_bm_pkg;
    localparam int          DATA_W      = 36;
    localparam int          DEPTH       = 256;
    localparam int          ADDR_W      = 8;
    localparam int          PTR_W       = 9;
    localparam logic [8:0]  DEPTH_CNT   = 9'h100;
    localparam logic [8:0]  AE_OFFSET   = 9'h008;
    localparam logic [8:0]  AF_OFFSET   = 9'h008;
    localparam logic [35:0] MASK_LONG   = 36'hf_ffff_ffff;
    localparam logic [35:0] MASK_WORD   = 36'h0_0003_ffff;
    localparam logic [35:0] MASK_BYTE   = 36'h0_0000_01ff;
    localparam int          FILL_CLKS   = 3;
    localparam int          SPACE_CLKS  = 2;
    localparam int          CHAIN_FWD   = 4; // faster port clock drives chains [R17] [R18] [R19]
    localparam int          CHAIN_BACK  = 3;

    typedef enum logic [1:0] {SIZE_LONG, SIZE_WORD, SIZE_BYTE} busSize_e;

    function automatic busSize_e decodeSize(input logic busMatch, input logic sizeSel);
        if (!busMatch) return SIZE_LONG;
        return sizeSel ? SIZE_BYTE : SIZE_WORD;
    endfunction

    function automatic logic [35:0] laneMask(input busSize_e sz);
        case (sz)
            SIZE_WORD: return MASK_WORD;
            SIZE_BYTE: return MASK_BYTE;
            default:   return MASK_LONG;
        endcase
    endfunction

    function automatic logic [1:0] lastPortion(input busSize_e sz);
        case (sz)
            SIZE_WORD: return 2'h1;
            SIZE_BYTE: return 2'h3;
            default:   return 2'h0;
        endcase
    endfunction
endpackage

// [src/portion_select.sv]
/*
 * Picks one port B portion of a long word and places it on the low lines.
 * Assumes the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none
module portion_select (
    input  wire logic [35:0]           longWord,
    input  wire fifo_bm_pkg::busSize_e busSize,
    input  wire logic                  bigEndian,
    input  wire logic [1:0]            portion,
    output logic [35:0]                laneOut
);
    logic [1:0] slot;

    always_comb begin
        slot    = 2'h0;
        laneOut = longWord;                                          // [R1]
        case (busSize)
            fifo_bm_pkg::SIZE_WORD: begin
                // upper lines read as zero, any value is allowed there
                slot    = (portion[0] ^ bigEndian) ? 2'h1 : 2'h0;    // [R3]
                laneOut = {18'h0_0000, slot[0] ? longWord[35:18] : longWord[17:0]}; // [R5]
            end
            fifo_bm_pkg::SIZE_BYTE: begin
                slot    = bigEndian ? 2'h3 - portion : portion;      // [R4]
                laneOut = {27'h000_0000, longWord[slot*9 +: 9]};     // [R6]
            end
            default: laneOut = longWord;
        endcase
    end
endmodule // portion_select
`default_nettype wire

// [verification/fifo_bm_sva.sv]
/* link checker for the FIFO device and controller ends.
   expects the interface signals by name from the bench top. */
`timescale 1ns/10ps
`default_nettype none
module fifo_bm_sva (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic masterResetN,
    input wire logic portAChipSelectN,
    input wire logic portAWriteRead,
    input wire logic portAEnable,
    input wire logic portAMailSelect,
    input wire logic portBChipSelectN,
    input wire logic portBWriteRead,
    input wire logic portBEnable,
    input wire logic portBMailSelect,
    input wire logic busMatchSelect,
    input wire logic sizeSelect,
    input wire logic fallThroughMode,
    input wire logic emptyFlagN,
    input wire logic fullFlagN,
    input wire logic mailToBFlagN,
    input wire logic mailToAFlagN
);
    wire logic       aOp = !portAChipSelectN && portAEnable;
    wire logic       bOp = !portBChipSelectN && portBEnable;
    wire logic       aWr = aOp && portAWriteRead && !portAMailSelect && fullFlagN;
    wire logic       bRd = bOp && portBWriteRead && !portBMailSelect && emptyFlagN;
    wire logic       aM1 = aOp && portAWriteRead && portAMailSelect;
    wire logic       bM1 = bOp && portBWriteRead && portBMailSelect;
    wire logic       bM2 = bOp && !portBWriteRead && portBMailSelect;
    wire logic [1:0] lastP = !busMatchSelect ? 2'h0 : (sizeSelect ? 2'h3 : 2'h1);
    logic      [1:0] part_r;

    // own portion count, so the flag checks do not lean on the device's
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            part_r <= 2'h0;
        else if (!masterResetN)
            part_r <= 2'h0;
        else if (bRd)
            part_r <= (part_r == lastP) ? 2'h0 : part_r + 2'h1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n || !masterResetN);

    property p_fill_std; aWr && !emptyFlagN && !fallThroughMode |-> ##3 emptyFlagN; endproperty
    a_fill_std: assert property (p_fill_std) else $error("late empty flag");
    property p_fill_ft; aWr && !emptyFlagN && fallThroughMode |-> ##4 emptyFlagN; endproperty
    a_fill_ft: assert property (p_fill_ft) else $error("late ready flag");
    property p_part; bRd && busMatchSelect && part_r != lastP |=> emptyFlagN; endproperty
    a_part: assert property (p_part) else $error("empty on partial word");
    property p_space; bRd && !fullFlagN && part_r == lastP |-> ##3 fullFlagN; endproperty
    a_space: assert property (p_space) else $error("late full flag");
    property p_static; $past(masterResetN) |-> $stable({busMatchSelect, sizeSelect}); endproperty
    a_static: assert property (p_static) else $error("size select moved");
    property p_m1set; aM1 && mailToBFlagN |=> !mailToBFlagN; endproperty
    a_m1set: assert property (p_m1set) else $error("mail flag not set");
    property p_m1clr; bM1 |=> mailToBFlagN; endproperty
    a_m1clr: assert property (p_m1clr) else $error("mail flag not cleared");
    property p_m2set; bM2 && mailToAFlagN |=> !mailToAFlagN; endproperty
    a_m2set: assert property (p_m2set) else $error("reply flag not set");
endmodule // fifo_bm_sva
`default_nettype wire

// [verification/fifo_port_b_bus_matching_flags_tb.sv]
/* bench for the FIFO device and controller ends joined by their link.
   assumes one 20 MHz clock; stimulus enters at the controller's user ports. */
`timescale 1ns/10ps
`default_nettype none
module fifo_port_b_bus_matching_flags_tb;
    logic        mclk = 1'b0, arst_n = 1'b0, chainMode = 1'b0;
    logic        bm = 1'b0, sz = 1'b0, be = 1'b0, ft = 1'b0, uRst = 1'b0;
    logic        uW = 1'b0, uWM = 1'b0, uR = 1'b0, uRM = 1'b0, uMW = 1'b0, uMR = 1'b0;
    logic [35:0] uWD = 36'h0, uMD = 36'h0, rData, mData, msk;
    logic        wDone, refused, rValid, mValid;
    int          bad_count = 0, samples_checked = 0, m, n;

    fifo_bm_if lnk (.mclk(mclk), .arst_n(arst_n));
    fifo_bm_device i_fifo_bm_device (.bus(lnk));
    fifo_bm_host i_fifo_bm_host (.bus(lnk), .chainMode(chainMode), .cfgBusMatch(bm),
        .cfgSize(sz), .cfgBigEndian(be), .cfgFallThrough(ft), .userResetN(uRst),
        .userWrite(uW), .userWriteMail(uWM), .userWriteData(uWD), .userRead(uR),
        .userReadMail(uRM), .userMailWrite(uMW), .userMailData(uMD), .userMailRead(uMR),
        .writeDone(wDone), .refused(refused), .readData(rData), .readValid(rValid),
        .mailData(mData), .mailValid(mValid));
    fifo_bm_sva i_fifo_bm_sva (.mclk(mclk), .arst_n(arst_n), .masterResetN(lnk.masterResetN),
        .portAChipSelectN(lnk.portAChipSelectN), .portAWriteRead(lnk.portAWriteRead),
        .portAEnable(lnk.portAEnable), .portAMailSelect(lnk.portAMailSelect),
        .portBChipSelectN(lnk.portBChipSelectN), .portBWriteRead(lnk.portBWriteRead),
        .portBEnable(lnk.portBEnable), .portBMailSelect(lnk.portBMailSelect),
        .busMatchSelect(lnk.busMatchSelect), .sizeSelect(lnk.sizeSelect),
        .fallThroughMode(lnk.fallThroughMode), .emptyFlagN(lnk.emptyFlagN),
        .fullFlagN(lnk.fullFlagN), .mailToBFlagN(lnk.mailToBFlagN),
        .mailToAFlagN(lnk.mailToAFlagN));

    task automatic chk(input logic [35:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic got, exp);
        chk({35'h0, got}, {35'h0, exp});
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // endian and fall-through reach the device only through this reset pulse
    task automatic cfg(input logic b, s, e, f);
        @(posedge mclk);
        {bm, sz, be, ft, uRst} <= {b, s, e, f, 1'b0};
        repeat (4) @(posedge mclk);
        uRst <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    task automatic wr(input logic wm, input logic [35:0] d);
        @(posedge mclk);
        {uW, uWM, uWD} <= {1'b1, wm, d};
        @(posedge mclk);
        uW <= 1'b0;
        #1;
        for (n = 0; n < 20 && wDone !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chkf(wDone, 1'b1);
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic rm, input logic [35:0] ex, mk);
        @(posedge mclk);
        {uR, uRM} <= {1'b1, rm};
        @(posedge mclk);
        uR <= 1'b0;
        #1;
        for (n = 0; n < 20 && rValid !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chkf(rValid, 1'b1);
        chk(rData & mk, ex);
    endtask
    task automatic mail2(input logic [35:0] d, mk);
        @(posedge mclk);
        {uMW, uMD} <= {1'b1, d};
        @(posedge mclk);
        uMW <= 1'b0;
        repeat (3) @(posedge mclk);
        uMR <= 1'b1;
        @(posedge mclk);
        uMR <= 1'b0;
        #1;
        for (n = 0; n < 20 && mValid !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk(mData & mk, d & mk);
    endtask
    task automatic seq(input logic b, s, e, f);
        int np, w, k, sh;
        logic [35:0] d, mk;
        np = !b ? 1 : (s ? 4 : 2);
        w = 36 / np;
        mk = (36'h1 << w) - 36'h1;
        d = 36'h9_a5c3_1e7b;
        cfg(b, s, e, f);
        be <= !e;
        wr(1'b0, d);
        wr(1'b0, ~d);
        for (k = 0; k < 2 * np; k++) begin
            sh = e ? 36 - w * (k % np + 1) : w * (k % np);
            rd(1'b0, ((k < np ? d : ~d) >> sh) & mk, mk);
        end
        repeat (3) @(posedge mclk);
        #1;
        chkf(lnk.emptyFlagN, 1'b0);
    endtask

    initial begin
        forever #25 mclk = ~mclk;
    end
    initial begin
        #1000000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        for (m = 0; m < 5; m++) seq(m != 0, m > 2, m[0], m[1]);
        for (m = 0; m < 2; m++) begin
            msk = m[0] ? fifo_bm_pkg::MASK_BYTE : fifo_bm_pkg::MASK_WORD;
            cfg(1'b1, m[0], 1'b0, 1'b0);
            wr(1'b1, 36'h9_8765_4321);
            rd(1'b1, 36'h9_8765_4321 & msk, msk);
            mail2(36'h6_abcd_ef01, msk);
        end
        cfg(1'b1, 1'b0, 1'b1, 1'b0);
        for (m = 0; m < 256; m++) begin
            wr(1'b0, {2{18'(m)}});
            if (m == 7 || m == 8) chkf(lnk.almostEmptyFlagN, m == 8);
        end
        chkf(lnk.fullFlagN, 1'b0);
        // word mode: one long word frees space only at its second half
        for (m = 0; m < 18; m++) begin
            rd(1'b0, 36'(m / 2), fifo_bm_pkg::MASK_WORD);
            repeat (2) @(posedge mclk);
            #1;
            if (m < 2) chkf(lnk.fullFlagN, m == 1);
            if (m > 14) chkf(lnk.almostFullFlagN, m == 17);
        end
        print_verdict;
    end
endmodule // fifo_port_b_bus_matching_flags_tb
`default_nettype wire
